// File: rtl/ipe_arbiter.sv
`timescale 1ns/100ps
`include "ipe_consts.svh"
module ipe_arbiter #(
   parameter int N = `IPE_NUM_SRC
) (
   // Levels per source
   input  wire logic [2*N-1:0]   levels,
   // Winner
   output ipe_pkg::ipe_win_s     win
);
   always_comb begin
      win = '0;
      for (int i = 0; i < N; i++) begin
         if (levels[2*i +: 2] > win.level) begin
            win.valid = 1'b1;
            win.level = levels[2*i +: 2];
            win.index = 5'(i);
         end
      end
   end
endmodule

// File: rtl/ipe_bank.sv
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`include "ipe_consts.svh"
// Contract
// R01: An enable pair is a level code: 00 off, 01 low, 10 medium, 11 high.
// R02: Group 0 bits: timer B 6, timer A 5, serial rx 4, tx 3, converter 0.
// R03: Group 1 bits: port A 5 to 0, 6 pin or comparator, 7 pin or voltage.
// R04: Group 2 bits 3 to 0 serve port C pins 3 to 0; 7 to 4 are reserved.
// R05: Software writes zero to reserved enable bits of groups 0 and 2.
// R06: A source request sets its request bit; its pair decides the level.
// R07: Requests pass only under global enable, cleared by ack, disable, reset.
// R08: A select bit picks pin (0) or alternate source (1) per shared request.
// R09: Highest pending level wins; ties go to the lowest group, then bit.
module ipe_bank (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rst_b,
   // Register port
   input  wire ipe_pkg::ipe_bus_s    bus,
   output logic [7:0]                rdata,
   // Group 0 sources, same clock
   input  wire logic                 src_timer_b,
   input  wire logic                 src_timer_a,
   input  wire logic                 src_serial_rx,
   input  wire logic                 src_serial_tx,
   input  wire logic                 src_converter,
   // Shared alternate sources, same clock
   input  wire logic                 src_comparator,
   input  wire logic                 src_low_voltage_detector,
   // Pins
   input  wire logic [7:0]           porta_pin,
   input  wire logic [3:0]           portc_pin,
   // Core side
   input  wire logic                 enable_interrupts_instruction,
   input  wire logic                 disable_interrupts_instruction,
   input  wire logic                 core_ack,
   output logic                      core_irq,
   output logic [4:0]                core_vector,
   output ipe_pkg::ipe_level_t       core_level,
   // Interrupt output
   output logic                      irq
);
   // ****************************************
   // Pin synchronisers and edge detect
   // ****************************************
   logic [11:0] pin_s1_q, pin_s2_q, pin_s3_q;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_q <= 12'h000;
         pin_s2_q <= 12'h000;
         pin_s3_q <= 12'h000;
      end else begin
         pin_s1_q <= {portc_pin, porta_pin};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end
   wire [11:0] pin_rise = pin_s2_q & ~pin_s3_q;

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] g0_high_q, g0_low_q, g1_high_q, g1_low_q;
   logic [7:0] g2_high_q, g2_low_q, req0_q, req1_q, req2_q;
   logic [7:0] select_q, ien_q;
   logic [1:0] istat_q;
   logic       gie_q;
   ipe_pkg::ipe_state_e state_q, state_d;
   ipe_pkg::ipe_win_s   win;

   wire wr_g0h  = bus.wr && bus.addr == `IPE_OFS_G0_HIGH;
   wire wr_g0l  = bus.wr && bus.addr == `IPE_OFS_G0_LOW;
   wire wr_g1h  = bus.wr && bus.addr == `IPE_OFS_G1_HIGH;
   wire wr_g1l  = bus.wr && bus.addr == `IPE_OFS_G1_LOW;
   wire wr_g2h  = bus.wr && bus.addr == `IPE_OFS_G2_HIGH;
   wire wr_g2l  = bus.wr && bus.addr == `IPE_OFS_G2_LOW;
   wire wr_req0 = bus.wr && bus.addr == `IPE_OFS_REQ0;
   wire wr_req1 = bus.wr && bus.addr == `IPE_OFS_REQ1;
   wire wr_req2 = bus.wr && bus.addr == `IPE_OFS_REQ2;
   wire wr_sel  = bus.wr && bus.addr == `IPE_OFS_SELECT;
   wire wr_ctrl = bus.wr && bus.addr == `IPE_OFS_CTRL;
   wire wr_iclr = bus.wr && bus.addr == `IPE_OFS_ICLR;
   wire wr_ien  = bus.wr && bus.addr == `IPE_OFS_IEN;

   // ****************************************
   // Request capture
   // ****************************************
   wire sel_volt = select_q[`IPE_SEL_VOLT];
   wire sel_cmp  = select_q[`IPE_SEL_CMP];
   wire shr7 = sel_volt ? src_low_voltage_detector : pin_rise[7]; // [R08]
   wire shr6 = sel_cmp ? src_comparator : pin_rise[6]; // [R08]
   wire [7:0] set0 = {1'b0, src_timer_b, src_timer_a, src_serial_rx,
                      src_serial_tx, 2'b00, src_converter}; // [R02]
   wire [7:0] set1 = {shr7, shr6, pin_rise[5:0]}; // [R03]
   wire [7:0] set2 = {4'h0, pin_rise[11:8]}; // [R04]

   wire ack_take = core_ack && state_q == ipe_pkg::IPE_REQ;
   wire [23:0] ack_clr = ack_take ? 24'(1) << win.index : 24'h000000;

   // Set wins over software clear and acknowledge
   wire [7:0] req0_d = ((wr_req0 ? bus.wdata : req0_q) & ~ack_clr[7:0]
                        | set0) & `IPE_G0_MASK; // [R06]
   wire [7:0] req1_d = ((wr_req1 ? bus.wdata : req1_q) & ~ack_clr[15:8]
                        | set1) & `IPE_G1_MASK; // [R06]
   wire [7:0] req2_d = ((wr_req2 ? bus.wdata : req2_q) & ~ack_clr[23:16]
                        | set2) & `IPE_G2_MASK; // [R06]

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         req0_q <= `IPE_RST_BYTE;
         req1_q <= `IPE_RST_BYTE;
         req2_q <= `IPE_RST_BYTE;
      end else begin
         req0_q <= req0_d;
         req1_q <= req1_d;
         req2_q <= req2_d;
      end
   end

   // ****************************************
   // Enable pairs and control
   // ****************************************
   // Reserved bits are forced to zero in hardware as well
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         g0_high_q <= `IPE_RST_BYTE;
         g0_low_q  <= `IPE_RST_BYTE;
         g1_high_q <= `IPE_RST_BYTE;
         g1_low_q  <= `IPE_RST_BYTE;
         g2_high_q <= `IPE_RST_BYTE;
         g2_low_q  <= `IPE_RST_BYTE;
         select_q  <= `IPE_RST_BYTE;
         ien_q     <= `IPE_RST_BYTE;
      end else begin
         if (wr_g0h) g0_high_q <= bus.wdata & `IPE_G0_MASK; // [R05]
         if (wr_g0l) g0_low_q  <= bus.wdata & `IPE_G0_MASK; // [R05]
         if (wr_g1h) g1_high_q <= bus.wdata;
         if (wr_g1l) g1_low_q  <= bus.wdata;
         if (wr_g2h) g2_high_q <= bus.wdata & `IPE_G2_MASK; // [R05]
         if (wr_g2l) g2_low_q  <= bus.wdata & `IPE_G2_MASK; // [R05]
         if (wr_sel) select_q  <= bus.wdata & `IPE_SEL_MASK;
         if (wr_ien) ien_q     <= bus.wdata;
      end
   end

   // Clear by acknowledge, disable or direct write of zero
   wire gie_clr = ack_take || disable_interrupts_instruction
                  || (wr_ctrl && !bus.wdata[`IPE_CTRL_GIE]);
   wire gie_set = enable_interrupts_instruction
                  || (wr_ctrl && bus.wdata[`IPE_CTRL_GIE]);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         gie_q <= 1'b0; // [R07]
      end else if (gie_clr) begin
         gie_q <= 1'b0; // [R07]
      end else if (gie_set) begin
         gie_q <= 1'b1;
      end
   end

   // ****************************************
   // Priority decode
   // ****************************************
   wire [23:0] en_high = {g2_high_q, g1_high_q, g0_high_q};
   wire [23:0] en_low  = {g2_low_q, g1_low_q, g0_low_q};
   wire [23:0] pending = {req2_q, req1_q, req0_q};
   wire [47:0] levels;

   for (genvar i = 0; i < `IPE_NUM_SRC; i++) begin : g_slot
      ipe_level_slot u_slot (
         .en_high (en_high[i]),
         .en_low  (en_low[i]),
         .pending (pending[i]),
         .level   (levels[2*i +: 2])
      ); // [R01]
   end

   ipe_arbiter #(.N(`IPE_NUM_SRC)) u_arb (
      .levels (levels),
      .win    (win)
   ); // [R09]

   // ****************************************
   // Core handshake
   // ****************************************
   wire fwd = win.valid && gie_q; // [R07]
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ipe_pkg::IPE_IDLE: if (fwd) state_d = ipe_pkg::IPE_REQ;
         ipe_pkg::IPE_REQ: begin
            if (core_ack) state_d = ipe_pkg::IPE_WAIT;
            else if (!fwd) state_d = ipe_pkg::IPE_IDLE;
         end
         ipe_pkg::IPE_WAIT: state_d = ipe_pkg::IPE_IDLE;
         default: state_d = ipe_pkg::IPE_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_q     <= ipe_pkg::IPE_IDLE;
         core_vector <= 5'h00;
         core_level  <= `IPE_RST_LEVEL;
      end else begin
         state_q <= state_d;
         if (state_d == ipe_pkg::IPE_REQ && !ack_take) begin
            core_vector <= win.index; // [R09]
            core_level  <= win.level;
         end
      end
   end
   assign core_irq = state_q == ipe_pkg::IPE_REQ && fwd;

   // ****************************************
   // Interrupt status
   // ****************************************
   wire [1:0] ev = {fwd && state_q == ipe_pkg::IPE_IDLE, ack_take};
   wire [1:0] clr = wr_iclr ? bus.wdata[1:0] : 2'b00;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) istat_q <= 2'b00;
      else istat_q <= (istat_q & ~clr) | ev;
   end
   assign irq = |(istat_q & ien_q[1:0]);

   // ****************************************
   // Read data
   // ****************************************
   logic [7:0] rmux;
   always_comb begin
      unique case (bus.addr)
         `IPE_OFS_REQ0:    rmux = req0_q;
         `IPE_OFS_G0_HIGH: rmux = g0_high_q;
         `IPE_OFS_G0_LOW:  rmux = g0_low_q;
         `IPE_OFS_REQ1:    rmux = req1_q;
         `IPE_OFS_G1_HIGH: rmux = g1_high_q;
         `IPE_OFS_G1_LOW:  rmux = g1_low_q;
         `IPE_OFS_REQ2:    rmux = req2_q;
         `IPE_OFS_G2_HIGH: rmux = g2_high_q;
         `IPE_OFS_G2_LOW:  rmux = g2_low_q;
         `IPE_OFS_SELECT:  rmux = select_q;
         `IPE_OFS_CTRL:    rmux = {gie_q, 7'h00};
         `IPE_OFS_ISTAT:   rmux = {6'h00, istat_q};
         `IPE_OFS_IEN:     rmux = ien_q;
         default:          rmux = 8'h00;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) rdata <= 8'h00;
      else if (bus.rd) rdata <= rmux;
      else rdata <= 8'h00;
   end
endmodule

// File: rtl/ipe_consts.svh
`ifndef IPE_CONSTS_SVH
`define IPE_CONSTS_SVH
// ****************************************
// Register offsets
// ****************************************
`define IPE_OFS_REQ0    12'hFC0
`define IPE_OFS_G0_HIGH 12'hFC1
`define IPE_OFS_G0_LOW  12'hFC2
`define IPE_OFS_REQ1    12'hFC3
`define IPE_OFS_G1_HIGH 12'hFC4
`define IPE_OFS_G1_LOW  12'hFC5
`define IPE_OFS_REQ2    12'hFC6
`define IPE_OFS_G2_HIGH 12'hFC7
`define IPE_OFS_G2_LOW  12'hFC8
`define IPE_OFS_SELECT  12'hFCE
`define IPE_OFS_CTRL    12'hFCF
`define IPE_OFS_ISTAT   12'hFD0
`define IPE_OFS_ICLR    12'hFD1
`define IPE_OFS_IEN     12'hFD2
// ****************************************
// Field layouts and reset values
// ****************************************
`define IPE_G0_MASK     8'h79
`define IPE_G1_MASK     8'hFF
`define IPE_G2_MASK     8'h0F
`define IPE_SEL_MASK    8'hC0
`define IPE_SEL_VOLT    7
`define IPE_SEL_CMP     6
`define IPE_CTRL_GIE    7
`define IPE_RST_BYTE    8'h00
`define IPE_RST_LEVEL   2'h0
`define IPE_NUM_SRC     24
`define IPE_ISTAT_ACK   0
`define IPE_ISTAT_RAISE 1
`endif

// File: rtl/ipe_level_slot.sv
`timescale 1ns/100ps
`include "ipe_consts.svh"
module ipe_level_slot (
   // Enable pair and request
   input  wire logic             en_high,
   input  wire logic             en_low,
   input  wire logic             pending,
   // Effective level
   output ipe_pkg::ipe_level_t   level
);
   wire ipe_pkg::ipe_level_t code = {en_high, en_low};
   assign level = pending ? code : `IPE_RST_LEVEL;
endmodule

// File: rtl/ipe_pkg.sv
package ipe_pkg;
   typedef logic [1:0] ipe_level_t;
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } ipe_bus_s;
   typedef struct packed {
      logic       valid;
      ipe_level_t level;
      logic [4:0] index;
   } ipe_win_s;
   typedef enum logic [1:0] {
      IPE_IDLE = 2'b00,
      IPE_REQ  = 2'b01,
      IPE_WAIT = 2'b11
   } ipe_state_e;
endpackage

// File: tb/ipe_bank_bench.sv
`timescale 1ns/100ps
`include "ipe_consts.svh"
module ipe_bank_bench;
   logic                mclk = 1'b0;
   logic                rst_b = 1'b0;
   ipe_pkg::ipe_bus_s   bus = '0;
   logic [6:0]          src = 7'h00;
   logic [7:0]          porta_pin = 8'h00;
   logic [3:0]          portc_pin = 4'h0;
   logic                ei = 1'b0;
   logic                di = 1'b0;
   logic                slow = 1'b0;
   logic                rd_prev = 1'b0;
   logic                core_ack, core_irq, irq;
   logic [7:0]          rdata;
   logic [4:0]          core_vector;
   ipe_pkg::ipe_level_t core_level;
   logic [6:0]          taken;
   logic [7:0]          rq[$];
   logic [6:0]          aq[$];
   int                  mismatches = 0;
   int                  n_compared = 0;
   int                  p;
   always #50 mclk = ~mclk;
   ipe_bank ipe_bank_inst (.mclk(mclk), .rst_b(rst_b), .bus(bus),
      .rdata(rdata), .src_timer_b(src[6]), .src_timer_a(src[5]),
      .src_serial_rx(src[4]), .src_serial_tx(src[3]),
      .src_converter(src[2]), .src_comparator(src[1]),
      .src_low_voltage_detector(src[0]), .porta_pin(porta_pin),
      .portc_pin(portc_pin), .enable_interrupts_instruction(ei),
      .disable_interrupts_instruction(di), .core_ack(core_ack),
      .core_irq(core_irq), .core_vector(core_vector),
      .core_level(core_level), .irq(irq));
   ipe_core_model ipe_core_model_inst (.mclk(mclk), .rst_b(rst_b),
      .core_irq(core_irq), .core_vector(core_vector),
      .core_level(core_level), .slow(slow), .core_ack(core_ack),
      .taken(taken));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      if (mismatches == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      rq.push_back(e);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
   endtask
   task automatic pulse(input logic [6:0] s);
      @(posedge mclk);
      src <= s;
      @(posedge mclk);
      src <= 7'h00;
   endtask
   task automatic look(input logic [1:0] e);
      @(negedge mclk);
      chk({6'h00, core_irq, irq}, {6'h00, e});
   endtask
   task automatic drain;
      repeat (40) if (aq.size() > 0) @(negedge mclk);
      chk(8'(aq.size()), 8'h00);
   endtask
   task automatic serve(input logic [4:0] v, input logic [1:0] l);
      aq.push_back({v, l});
      wr(`IPE_OFS_CTRL, 8'h80);
      drain;
   endtask
   // ****************************************
   // Result watcher
   // ****************************************
   always @(posedge mclk) begin
      if (rd_prev) chk(rdata, rq.pop_front());
      if (core_ack === 1'b1) begin
         chk({1'b0, taken}, {1'b0, aq.pop_front()});
      end
      rd_prev <= bus.rd;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      complete_run;
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [11:0] ofs [6];
      logic [7:0]  msk [6];
      logic [7:0]  v;
      ofs = '{`IPE_OFS_G0_HIGH, `IPE_OFS_G0_LOW, `IPE_OFS_G1_HIGH,
              `IPE_OFS_G1_LOW, `IPE_OFS_G2_HIGH, `IPE_OFS_G2_LOW};
      msk = '{`IPE_G0_MASK, `IPE_G0_MASK, `IPE_G1_MASK, `IPE_G1_MASK,
              `IPE_G2_MASK, `IPE_G2_MASK};
      void'($urandom(32'h95EF));
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      for (int r = 0; r < 6; r++) rd(ofs[r], 8'h00);
      rd(12'h800, 8'h00);
      for (int r = 0; r < 6; r++) begin
         v = 8'($urandom) & msk[r];
         wr(ofs[r], v);
         rd(ofs[r], v);
      end
      for (int c = 0; c < 4; c++) begin
         wr(`IPE_OFS_G0_HIGH, c[1] ? 8'h40 : 8'h00);
         wr(`IPE_OFS_G0_LOW, c[0] ? 8'h40 : 8'h00);
         pulse(7'h40);
         rd(`IPE_OFS_REQ0, 8'h40);
         if (c != 0) begin
            serve(5'h06, 2'(c));
         end else begin
            wr(`IPE_OFS_CTRL, 8'h80);
            repeat (3) @(posedge mclk);
            look(2'b00);
            wr(`IPE_OFS_REQ0, 8'h00);
            wr(`IPE_OFS_CTRL, 8'h00);
         end
      end
      wr(`IPE_OFS_G0_HIGH, 8'h11);
      wr(`IPE_OFS_G0_LOW, 8'h31);
      pulse(7'h34);
      serve(5'h00, 2'h3);
      serve(5'h04, 2'h3);
      serve(5'h05, 2'h1);
      p = $urandom % 6;
      wr(`IPE_OFS_SELECT, 8'hC0);
      wr(`IPE_OFS_G1_HIGH, 8'hC0);
      wr(`IPE_OFS_G1_LOW, 8'h80 | (8'h01 << p));
      pulse(7'h03);
      rd(`IPE_OFS_REQ1, 8'hC0);
      serve(5'h0F, 2'h3);
      serve(5'h0E, 2'h2);
      @(posedge mclk);
      porta_pin <= (8'h01 << p) | 8'hC0;
      serve(5'(8 + p), 2'h1);
      rd(`IPE_OFS_REQ1, 8'h00);
      wr(`IPE_OFS_G2_HIGH, 8'h08);
      wr(`IPE_OFS_G2_LOW, 8'h08);
      @(posedge mclk);
      portc_pin <= 4'h8;
      serve(5'h13, 2'h3);
      slow <= 1'b1;
      pulse(7'h04);
      wr(`IPE_OFS_CTRL, 8'h80);
      @(posedge mclk);
      di <= 1'b1;
      @(posedge mclk);
      di <= 1'b0;
      look(2'b00);
      aq.push_back({5'h00, 2'h3});
      @(posedge mclk);
      ei <= 1'b1;
      @(posedge mclk);
      ei <= 1'b0;
      drain;
      wr(`IPE_OFS_IEN, 8'h00);
      look(2'b00);
      wr(`IPE_OFS_IEN, 8'h03);
      look(2'b01);
      wr(`IPE_OFS_ICLR, 8'h03);
      rd(`IPE_OFS_ISTAT, 8'h00);
      look(2'b00);
      repeat (4) @(posedge mclk);
      complete_run;
   end
endmodule

// File: tb/ipe_bank_monitor.sv
`timescale 1ns/100ps
`include "ipe_consts.svh"
// ****************************************
// Port checker
// ****************************************
module ipe_bank_monitor (
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                rst_b,
   // Register port
   input  wire ipe_pkg::ipe_bus_s   bus,
   input  wire logic [7:0]          rdata,
   // Core side
   input  wire logic                enable_interrupts_instruction,
   input  wire logic                disable_interrupts_instruction,
   input  wire logic                core_ack,
   input  wire logic                core_irq,
   input  wire logic [4:0]          core_vector,
   input  wire ipe_pkg::ipe_level_t core_level
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   a_rdata_idle_zero: assert property (!$past(bus.rd) |-> rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (
      $past(bus.rd) && $past(bus.addr) < 12'hFC0 |-> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_g0_reserved_zero: assert property (
      $past(bus.rd) && $past(bus.addr) == `IPE_OFS_G0_LOW
      |-> (rdata & 8'h86) == 8'h00)
      else $error("group 0 reserved bits not zero");
   a_g2_reserved_zero: assert property (
      $past(bus.rd) && ($past(bus.addr) == `IPE_OFS_G2_HIGH ||
      $past(bus.addr) == `IPE_OFS_G2_LOW) |-> rdata[7:4] == 4'h0)
      else $error("group 2 reserved bits not zero");
   a_ack_drops_irq: assert property (
      core_ack && !enable_interrupts_instruction && !bus.wr |=> !core_irq)
      else $error("request stays after acknowledge");
   a_disable_drops_irq: assert property (
      disable_interrupts_instruction && !enable_interrupts_instruction
      && !bus.wr |=> !core_irq[*2])
      else $error("request stays after disable");
   a_level_nonzero: assert property (core_irq |-> core_level != 2'h0)
      else $error("request with disabled level");
   a_vector_legal: assert property (
      core_irq |-> !(core_vector inside {5'h01, 5'h02, 5'h07})
      && core_vector < 5'h14)
      else $error("request from a reserved position");
endmodule
bind ipe_bank ipe_bank_monitor ipe_bank_monitor_inst (.mclk(mclk),
   .rst_b(rst_b), .bus(bus), .rdata(rdata),
   .enable_interrupts_instruction(enable_interrupts_instruction),
   .disable_interrupts_instruction(disable_interrupts_instruction),
   .core_ack(core_ack), .core_irq(core_irq), .core_vector(core_vector),
   .core_level(core_level));

// File: tb/ipe_core_model.sv
`timescale 1ns/100ps
// ****************************************
// Core that services requests
// ****************************************
module ipe_core_model (
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                rst_b,
   // Request from the bank
   input  wire logic                core_irq,
   input  wire logic [4:0]          core_vector,
   input  wire ipe_pkg::ipe_level_t core_level,
   // Service pace
   input  wire logic                slow,
   // Acknowledge and what was taken
   output logic                     core_ack,
   output logic [6:0]               taken
);
   logic [2:0] wait_q;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wait_q <= 3'h0;
         core_ack <= 1'b0;
         taken <= 7'h00;
      end else begin
         core_ack <= 1'b0;
         if (!core_irq || core_ack) begin
            wait_q <= 3'h0;
         end else if (wait_q == (slow ? 3'h5 : 3'h0)) begin
            core_ack <= 1'b1;
            taken <= {core_vector, core_level};
            wait_q <= 3'h0;
         end else begin
            wait_q <= wait_q + 3'h1;
         end
      end
   end
endmodule
